/* File: dsc_pkg.sv */
// Constants and types shared by the DMA source control block
package dsc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] DSC_OFS_CH0_CTRL = 8'h00;
  localparam logic [7:0] DSC_OFS_CH1_CTRL = 8'h04;
  localparam logic [7:0] DSC_OFS_CH0_PTR = 8'h08;
  localparam logic [7:0] DSC_OFS_CH1_PTR = 8'h0c;
  localparam logic [7:0] DSC_OFS_CH0_COUNT = 8'h10;
  localparam logic [7:0] DSC_OFS_CH1_COUNT = 8'h14;
  localparam logic [7:0] DSC_OFS_STATUS = 8'h18;

  // Field positions inside the 16-bit control word
  localparam int DSC_POS_SIZE = 15;
  localparam int DSC_POS_DIR = 14;
  localparam int DSC_POS_STEP_EN = 13;
  localparam int DSC_POS_BLK_SIDE = 12;
  localparam int DSC_POS_BLK_EN = 11;
  localparam int DSC_POS_RSV_HI = 10;
  localparam int DSC_POS_RSV_LO = 8;
  localparam int DSC_POS_CTRL_LO = 8;

  // Reset values
  localparam logic [7:0] DSC_CTRL_RESET = 8'h00;
  localparam logic [31:0] DSC_PTR_RESET = 32'h0000_0000;
  localparam logic [15:0] DSC_COUNT_RESET = 16'h0000;

  // Pointer step amounts
  localparam logic [31:0] DSC_STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] DSC_STEP_WORD = 32'h0000_0002;

  localparam int DSC_NUM_CHAN = 2;
  localparam int DSC_BUF_DEPTH = 2;

  // Transfer mode seen by the transfer engine
  typedef enum logic [1:0] {
    DSC_MODE_NORMAL,
    DSC_MODE_BLOCK_DST,
    DSC_MODE_BLOCK_SRC
  } dsc_mode_t;

  // Control byte of one channel, bits 15..8 of the control word
  typedef struct packed {
    logic transfer_size_sel;
    logic src_step_direction;
    logic src_step_enable;
    logic block_side_select;
    logic block_mode_enable;
    logic [2:0] reserved;
  } dsc_ctrl_t;

  // Transfer descriptor passed to the transfer engine
  typedef struct packed {
    logic chan;
    logic [31:0] addr;
    logic wordSize;
    dsc_mode_t mode;
  } dsc_desc_t;

endpackage

/* File: dsc_stream_if.sv */
// Valid/ready descriptor stream between the control logic and its buffer
`timescale 1ns/1ns
`default_nettype none
interface dsc_stream_if;
  import dsc_pkg::*;
  logic inValid;
  logic inReady;
  dsc_desc_t inData;
  logic outValid;
  logic outReady;
  dsc_desc_t outData;
  logic [1:0] level;

  modport producer (
    output inValid,
    output inData,
    input inReady,
    input outValid,
    input outData,
    output outReady,
    input level
  );

  modport buffer (
    input inValid,
    input inData,
    output inReady,
    output outValid,
    output outData,
    input outReady,
    output level
  );
endinterface
`default_nettype wire

/* File: dsc_skid_buffer.sv */
// Two-entry descriptor buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dsc_skid_buffer
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Stream
  dsc_stream_if.buffer strm
);

  typedef struct packed {
    dsc_desc_t [DSC_BUF_DEPTH-1:0] entry;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
  } dsc_buf_state_t;

  dsc_buf_state_t state_reg;
  dsc_buf_state_t state_next;
  logic push;
  logic pop;

  assign strm.inReady = (state_reg.count != 2'(DSC_BUF_DEPTH));
  assign strm.outValid = (state_reg.count != 2'd0);
  assign strm.outData = state_reg.entry[state_reg.rdPtr];
  assign strm.level = state_reg.count;
  assign push = strm.inValid && strm.inReady;
  assign pop = strm.outValid && strm.outReady;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.entry[state_reg.wrPtr] = strm.inData;
      state_next.wrPtr = ~state_reg.wrPtr;
    end
    if (pop) begin
      state_next.rdPtr = ~state_reg.rdPtr;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 2'd1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 2'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

/* File: dsc_source_ctrl.sv */
// Source-side transfer control for a two-channel DMA in full address mode
//
// Function
// - Size bit 15 selects byte transfers at 0, word transfers at 1.
// - Source update codes 00 and 10 keep the source pointer unchanged.
// - Source update code 01 increments the pointer after each completed transfer.
// - Pointer steps by 1 for byte transfers and 2 for word transfers.
// - Source update code 11 decrements the pointer after each completed transfer.
// - Block enable 0 gives normal mode; block side bit is ignored.
// - With block enable bit 11 set, bit 12 picks destination 0 or source 1.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module dsc_source_ctrl
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer requests from the activation logic
  input wire logic reqValid,
  input wire logic reqChan,
  output logic reqReady,
  // Descriptors to the transfer engine
  output logic descValid,
  input wire logic descReady,
  output logic descChan,
  output logic [31:0] descAddr,
  output logic descWordSize,
  output logic [1:0] descMode,
  // Completion strobes from the transfer engine, one per channel
  input wire logic [DSC_NUM_CHAN-1:0] xferDone
);

  typedef enum logic [2:0] {
    DSC_REG_CTRL,
    DSC_REG_PTR,
    DSC_REG_COUNT,
    DSC_REG_STATUS,
    DSC_REG_NONE
  } dsc_reg_kind_t;

  typedef struct packed {
    dsc_ctrl_t [DSC_NUM_CHAN-1:0] ctrl;
    logic [DSC_NUM_CHAN-1:0][31:0] ptr;
    logic [DSC_NUM_CHAN-1:0][15:0] count;
    logic ack;
    logic err;
    logic [31:0] rdData;
  } dsc_state_t;

  dsc_state_t state_reg;
  dsc_state_t state_next;
  dsc_stream_if strm ();

  // Register kind for an address
  function automatic dsc_reg_kind_t regKind(input logic [7:0] addr);
    dsc_reg_kind_t kind;
    kind = DSC_REG_NONE;
    unique case (addr)
      DSC_OFS_CH0_CTRL, DSC_OFS_CH1_CTRL: kind = DSC_REG_CTRL;
      DSC_OFS_CH0_PTR, DSC_OFS_CH1_PTR: kind = DSC_REG_PTR;
      DSC_OFS_CH0_COUNT, DSC_OFS_CH1_COUNT: kind = DSC_REG_COUNT;
      DSC_OFS_STATUS: kind = DSC_REG_STATUS;
      default: kind = DSC_REG_NONE;
    endcase
    return kind;
  endfunction

  // Channel addressed by a per-channel register offset
  function automatic logic regChan(input logic [7:0] addr);
    return (addr == DSC_OFS_CH1_CTRL) || (addr == DSC_OFS_CH1_PTR)
      || (addr == DSC_OFS_CH1_COUNT);
  endfunction

  // Source pointer after one completed transfer
  function automatic logic [31:0] nextPtr(input logic [31:0] ptr, input dsc_ctrl_t ctrl);
    logic [31:0] step;
    logic [31:0] result;
    step = ctrl.transfer_size_sel ? DSC_STEP_WORD : DSC_STEP_BYTE;
    result = ptr;
    if (ctrl.src_step_enable) begin
      if (ctrl.src_step_direction) begin
        result = ptr - step;
      end else begin
        result = ptr + step;
      end
    end
    return result;
  endfunction

  // Transfer mode from a control byte
  function automatic dsc_mode_t modeOf(input dsc_ctrl_t ctrl);
    dsc_mode_t mode;
    if (!ctrl.block_mode_enable) begin
      mode = DSC_MODE_NORMAL;
    end else if (ctrl.block_side_select) begin
      mode = DSC_MODE_BLOCK_SRC;
    end else begin
      mode = DSC_MODE_BLOCK_DST;
    end
    return mode;
  endfunction

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] laneMerge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] result;
    result = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        result[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return result;
  endfunction

  logic access;
  logic wrTake;
  dsc_reg_kind_t accKind;
  logic accChan;
  logic [31:0] readWord;

  assign access = psel && penable;
  assign wrTake = access && state_reg.ack && pwrite && !state_reg.err;
  assign accKind = regKind(paddr);
  assign accChan = regChan(paddr);

  // Read multiplexer
  always_comb begin
    readWord = 32'h0000_0000;
    unique case (accKind)
      DSC_REG_CTRL: begin
        readWord[DSC_POS_SIZE:DSC_POS_CTRL_LO] = state_reg.ctrl[accChan];
      end
      DSC_REG_PTR: begin
        readWord = state_reg.ptr[accChan];
      end
      DSC_REG_COUNT: begin
        readWord[15:0] = state_reg.count[accChan];
      end
      DSC_REG_STATUS: begin
        readWord[1:0] = strm.level;
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  end

  // Descriptor formed from the requesting channel's own settings
  assign strm.inValid = reqValid;
  assign strm.inData.chan = reqChan;
  assign strm.inData.addr = state_reg.ptr[reqChan];
  assign strm.inData.wordSize = state_reg.ctrl[reqChan].transfer_size_sel;
  assign strm.inData.mode = modeOf(state_reg.ctrl[reqChan]);
  assign reqReady = strm.inReady;

  dsc_skid_buffer u_buffer (
    .ref_clk(ref_clk),
    .srst(srst),
    .strm(strm)
  );

  assign strm.outReady = descReady;
  assign descValid = strm.outValid;
  assign descChan = strm.outData.chan;
  assign descAddr = strm.outData.addr;
  assign descWordSize = strm.outData.wordSize;
  assign descMode = strm.outData.mode;

  // Answer in the second access cycle
  assign pready = state_reg.ack;
  assign pslverr = state_reg.ack && state_reg.err;
  assign prdata = state_reg.rdData;

  always_comb begin
    state_next = state_reg;
    state_next.ack = access && !state_reg.ack;
    state_next.err = 1'b0;
    if (access && !state_reg.ack) begin
      state_next.err = (accKind == DSC_REG_NONE)
        || (pwrite && (accKind == DSC_REG_STATUS));
      state_next.rdData = pwrite ? 32'h0000_0000 : readWord;
    end
    // Per-channel pointer stepping and completion counting
    for (int c = 0; c < DSC_NUM_CHAN; c++) begin
      if (xferDone[c]) begin
        state_next.ptr[c] = nextPtr(state_reg.ptr[c], state_reg.ctrl[c]);
        state_next.count[c] = state_reg.count[c] + 16'h0001;
      end
    end
    // Software write wins over a same-cycle step
    if (wrTake) begin
      unique case (accKind)
        DSC_REG_CTRL: begin
          if (pstrb[1]) begin
            state_next.ctrl[accChan] = pwdata[DSC_POS_SIZE:DSC_POS_CTRL_LO];
          end
        end
        DSC_REG_PTR: begin
          state_next.ptr[accChan] = laneMerge(state_reg.ptr[accChan], pwdata, pstrb);
        end
        DSC_REG_COUNT: begin
          state_next.count[accChan] = DSC_COUNT_RESET;
        end
        default: begin
          state_next.ack = state_next.ack;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int c = 0; c < DSC_NUM_CHAN; c++) begin
        state_reg.ctrl[c] <= DSC_CTRL_RESET;
        state_reg.ptr[c] <= DSC_PTR_RESET;
        state_reg.count[c] <= DSC_COUNT_RESET;
      end
      state_reg.ack <= 1'b0;
      state_reg.err <= 1'b0;
      state_reg.rdData <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

/* File: dsc_source_ctrl_asserts.sv */
// Port-level checks for the DMA source control block
`timescale 1ns/1ns
`default_nettype none
module dsc_source_ctrl_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Streams
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic descValid,
  input wire logic descReady,
  input wire logic [31:0] descAddr,
  input wire logic descWordSize,
  input wire logic [1:0] descMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic taken;
  logic bad;
  assign taken = psel && penable && !pready;
  assign bad = (paddr > 8'h18) || (paddr[1:0] != 2'h0) || (pwrite && paddr == 8'h18);
  AST_ONE_WAIT: assert property (taken |=> pready)
    else $error("pready not one cycle after access start");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RESET_IDLE: assert property ($fell(srst) |-> !pready && !descValid && reqReady)
    else $error("outputs not idle after reset");
  AST_ERR_BAD: assert property (taken && bad |=> pslverr)
    else $error("bad access not refused");
  AST_ERR_GOOD: assert property (taken && !bad |=> !pslverr)
    else $error("good access refused");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_DESC_HOLD: assert property (descValid && !descReady |=> descValid && $stable(descAddr)
    && $stable(descWordSize) && $stable(descMode))
    else $error("descriptor changed while stalled");
  AST_MODE_LEGAL: assert property (descValid |-> descMode != 2'h3)
    else $error("illegal descriptor mode");
  AST_REQ_TO_DESC: assert property (reqValid && reqReady && !descValid |=> descValid)
    else $error("request did not give a descriptor");
  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property (descValid && descReady);
endmodule
bind dsc_source_ctrl dsc_source_ctrl_asserts chk_u (.ref_clk, .srst, .paddr, .psel, .penable,
  .pwrite, .pready, .pslverr, .reqValid, .reqReady, .descValid, .descReady, .descAddr,
  .descWordSize, .descMode);
`default_nettype wire

/* File: dsc_source_ctrl_bench.sv */
// Self-checking testbench for the DMA source control block
`timescale 1ns/1ns
`default_nettype none
module dsc_source_ctrl_bench
  import dsc_pkg::*;
;
  logic ref_clk = 0;
  logic srst = 1;
  logic [7:0] paddr = 8'h00;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = 32'h0, prdata, r, ex;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, reqValid = 0, reqChan = 0, reqReady;
  logic descValid, descReady = 0, descChan, descWordSize;
  logic [31:0] descAddr;
  logic [1:0] descMode;
  logic [1:0] xferDone = 2'h0;
  int errors = 0;
  int cmp_count = 0;
  dsc_source_ctrl dut_u (.ref_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reqValid, .reqChan, .reqReady, .descValid, .descReady,
    .descChan, .descAddr, .descWordSize, .descMode, .xferDone);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 20) begin
      errors++;
      final_report();
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hang(n);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic req(input logic c);
    int n = 0;
    reqValid <= 1;
    reqChan <= c;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 20);
    hang(n);
    reqValid <= 0;
    @(posedge ref_clk);
  endtask
  task automatic pop(input logic c, input logic [31:0] a, input logic w, input logic [1:0] m);
    int n = 0;
    descReady <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (descValid !== 1'b1 && n < 20);
    hang(n);
    chk("desc", {descChan, descAddr, descWordSize, descMode}, {c, a, w, m});
    descReady <= 0;
    @(posedge ref_clk);
  endtask
  initial begin
    logic [2:0] i;
    repeat (3) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    apb(DSC_OFS_CH1_CTRL, 0, 0);
    chk("ch1 reset", r, 32'h0);
    apb(DSC_OFS_CH0_CTRL, 1, 32'hffff_f8ff);
    apb(DSC_OFS_CH0_CTRL, 0, 0);
    chk("ch0 ctrl", r, 32'h0000_f800);
    apb(DSC_OFS_CH1_CTRL, 0, 0);
    chk("ch1 ctrl", r, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      apb(DSC_OFS_CH0_CTRL, 1, {16'h0, i, 5'h0, 8'h0});
      apb(DSC_OFS_CH0_PTR, 1, 32'h100);
      xferDone <= 2'h1;
      @(posedge ref_clk);
      xferDone <= 2'h0;
      @(posedge ref_clk);
      ex = i[1:0] == 2'h1 ? 32'h100 + (i[2] ? 2 : 1) :
           i[1:0] == 2'h3 ? 32'h100 - (i[2] ? 2 : 1) : 32'h100;
      apb(DSC_OFS_CH0_PTR, 0, 0);
      chk("ptr", r, ex);
      req(0);
      pop(0, ex, i[2], 2'h0);
    end
    apb(DSC_OFS_CH0_COUNT, 0, 0);
    chk("ch0 count", r, 32'h8);
    apb(DSC_OFS_CH1_COUNT, 0, 0);
    chk("ch1 count", r, 32'h0);
    apb(DSC_OFS_CH0_COUNT, 1, 0);
    apb(DSC_OFS_CH0_COUNT, 0, 0);
    chk("count clear", r, 32'h0);
    $display("test stepping done");
    for (int k = 0; k < 4; k++) begin
      i = k[2:0];
      apb(DSC_OFS_CH1_CTRL, 1, {16'h0, 3'h0, i[1:0], 3'h0, 8'h0});
      req(1);
      pop(1, 32'h0, 0, !i[0] ? 2'h0 : (i[1] ? 2'h2 : 2'h1));
    end
    pstrb <= 4'hd;
    apb(DSC_OFS_CH1_CTRL, 1, 32'h0);
    pstrb <= 4'h2;
    apb(DSC_OFS_CH1_PTR, 1, 32'h1234_5678);
    pstrb <= 4'hf;
    apb(DSC_OFS_CH1_CTRL, 0, 0);
    chk("ch1 lanes", r, 32'h0000_1800);
    apb(DSC_OFS_CH1_PTR, 0, 0);
    chk("ptr lanes", r, 32'h0000_5600);
    xferDone <= 2'h2;
    @(posedge ref_clk);
    xferDone <= 2'h0;
    apb(DSC_OFS_CH0_COUNT, 0, 0);
    chk("ch0 count kept", r, 32'h0);
    apb(DSC_OFS_CH1_PTR, 0, 0);
    chk("ptr fixed", r, 32'h0000_5600);
    $display("test modes done");
    req(0);
    req(0);
    chk("full", reqReady, 0);
    apb(DSC_OFS_STATUS, 0, 0);
    chk("level", r, 32'h2);
    pop(0, 32'hfe, 1, 2'h0);
    pop(0, 32'hfe, 1, 2'h0);
    apb(DSC_OFS_STATUS, 1, 0);
    chk("ro err", e, 1);
    apb(8'h40, 0, 0);
    chk("map err", e, 1);
    $display("test buffer and errors done");
    final_report();
  end
endmodule
`default_nettype wire
